// ---- src/spp_pkg.sv ----
// Constants and types for the scan-port flash programming block.
// Assumes one system clock domain and one test-clock domain.
package spp_pkg;

    // -------------------------------------------------------------
    // Instruction codes and register widths
    // -------------------------------------------------------------
    localparam int          IR_W       = 4;
    localparam int          CMD_W      = 15;
    localparam int          BYTE_W     = 8;
    localparam int          UNL_W      = 16;
    localparam logic [3:0]  IR_RESET   = 4'hc;
    localparam logic [3:0]  IR_UNLOCK  = 4'h4;
    localparam logic [3:0]  IR_CMD     = 4'h5;
    localparam logic [3:0]  IR_LOAD    = 4'h6;
    localparam logic [3:0]  IR_READ    = 4'h7;
    localparam logic [3:0]  IR_BYPASS  = 4'hf;
    localparam logic [3:0]  IR_CAPTURE = 4'h1;

    // -------------------------------------------------------------
    // Values after reset, signature and counts
    // -------------------------------------------------------------
    localparam logic [15:0] UNLOCK_SIG  = 16'ha370;
    localparam logic [15:0] UNLOCK_RST  = 16'h0000;
    localparam logic [1:0]  DIS_CLR_CYC = 2'h2;
    localparam int          LOAD_MAX_TCK = 11;
    localparam int          RST_TMO_DEF = 16;

    // Test-port controller states, Gray-coded along the main path.
    typedef enum logic [3:0] {
        ST_TLR   = 4'h0, ST_RTI   = 4'h1, ST_SELDR = 4'h3, ST_CAPDR = 4'h2,
        ST_SHDR  = 4'h6, ST_EX1DR = 4'h7, ST_PSDR  = 4'h5, ST_EX2DR = 4'h4,
        ST_UPDR  = 4'hc, ST_SELIR = 4'hd, ST_CAPIR = 4'hf, ST_SHIR  = 4'he,
        ST_EX1IR = 4'ha, ST_PSIR  = 4'hb, ST_EX2IR = 4'h9, ST_UPIR  = 4'h8
    } spp_tap_t;

    // Kinds of event passed from the test clock to the system clock.
    typedef enum logic [1:0] {
        EV_CMD = 2'h0, EV_LOAD = 2'h1, EV_READ = 2'h3
    } spp_ev_t;

endpackage

// ---- src/spp_scan_prog.sv ----
// Scan-port flash programming logic: controller, instruction register,
// reset, unlock, command and page-byte registers, and the crossing to the
// system clock. Assumes flash logic on REF_CLK_I that answers within one
// cycle of a strobe, and a programmer that only drives TCK_I/TMS_I/TDI_I.
`timescale 1ns/1ns

// Summary of operation
// - Port usable only with enable fuse set and disable bit clear.
// - Disable bit set and external reset low: bit clears after two clocks.
// - All shift registers move least significant bit first.
// - Instruction register is 4 bits; each code picks one data register.
// - Run-test/idle generates the internal programming clocks.
// - Code 0xC selects the one-bit reset register; controller not reset.
// - A one in the reset register holds the part in reset at once.
// - After release the part stays in reset for the time-out period.
// - Code 0x4 selects 16-bit unlock register, compared at Update-DR.
// - Only the fixed signature unlocks; anything else leaves it locked.
// - Unlock register clears on power-on; programmer clears it on exit.
// - Code 0x5: 15-bit command register, capture result, shift both ways.
// - Update-DR applies the command; run-test/idle then executes it once.
// - Code 0x6 selects page byte register, the command register low byte.
// - Each page-load update copies the byte and writes it within 11 TCK.
// - Loads alternate low/high from low; pre-increment before each low byte except the first.
// - Code 0x7: each Capture-DR loads the selected flash byte to shift.
// - Reads alternate low/high from low; post-increment after each high.
module spp_scan_prog #(
    parameter int RST_TMO = spp_pkg::RST_TMO_DEF
) (
    // System clock, reset and device pins
    input  wire logic                       REF_CLK_I,
    input  wire logic                       NRST_I,
    input  wire logic                       EXT_RST_N_I,
    input  wire logic                       FUSE_EN_I,
    input  wire logic                       SCAN_DIS_SET_I,
    // Test port
    input  wire logic                       TCK_I,
    input  wire logic                       TMS_I,
    input  wire logic                       TDI_I,
    output logic                            TDO_O,
    output logic                            TDO_OE_O,
    // Flash side
    input  wire logic [spp_pkg::CMD_W-1:0]  FLASH_RESULT_I,
    input  wire logic [15:0]                FLASH_RDATA_I,
    output logic [spp_pkg::CMD_W-1:0]       FLASH_CMD_O,
    output logic                            FLASH_CMD_STB_O,
    output logic [spp_pkg::BYTE_W-1:0]      PAGE_BYTE_O,
    output logic                            PAGE_HIGH_O,
    output logic                            PAGE_WR_STB_O,
    output logic                            PC_INC_O,
    // Status
    output logic                            CORE_RST_O,
    output logic                            PROG_MODE_O,
    output logic                            SCAN_DIS_O,
    output logic                            SCAN_EN_O
);
    import spp_pkg::*;

    // -------------------------------------------------------------
    // System domain: disable bit, port enable, core reset
    // -------------------------------------------------------------
    logic [1:0]  xr_s_reg, rr_s_reg, pm_s_reg, dis_cnt_reg, dis_cnt_next;
    logic        dis_next;
    logic [15:0] tmo_reg, tmo_next;
    logic        rst_dr_reg;
    logic        prog_en_reg;

    wire xr_low   = !xr_s_reg[1];
    wire dis_clr  = SCAN_DIS_O && xr_low && dis_cnt_reg == DIS_CLR_CYC - 2'h1;
    wire rst_hold = rr_s_reg[1] || xr_low;

    // A software set in the clearing cycle wins over the clear.
    assign dis_cnt_next = (SCAN_DIS_O && xr_low) ? dis_cnt_reg + 2'h1 : 2'h0;
    assign dis_next     = SCAN_DIS_SET_I || (SCAN_DIS_O && !dis_clr);
    // The time-out reloads while any reset source is held.
    assign tmo_next = rst_hold ? 16'(RST_TMO) :
                      (tmo_reg != 16'h0000) ? tmo_reg - 16'h0001 : tmo_reg;

    // The external reset pin and cross-domain levels pass two flops before use.
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            xr_s_reg    <= 2'h0;
            rr_s_reg    <= 2'h0;
            pm_s_reg    <= 2'h0;
            dis_cnt_reg <= 2'h0;
            tmo_reg     <= 16'h0000;
            SCAN_DIS_O  <= 1'b0;
            SCAN_EN_O   <= 1'b0;
            CORE_RST_O  <= 1'b1;
            PROG_MODE_O <= 1'b0;
        end else begin
            xr_s_reg    <= {xr_s_reg[0], EXT_RST_N_I};
            rr_s_reg    <= {rr_s_reg[0], rst_dr_reg};
            pm_s_reg    <= {pm_s_reg[0], prog_en_reg};
            dis_cnt_reg <= dis_cnt_next;
            SCAN_DIS_O  <= dis_next;
            SCAN_EN_O   <= FUSE_EN_I && !SCAN_DIS_O;
            tmo_reg     <= tmo_next;
            CORE_RST_O  <= rst_hold || tmo_next != 16'h0000;
            PROG_MODE_O <= pm_s_reg[1];
        end
    end

    dis_clr_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (SCAN_DIS_O && xr_low && !SCAN_DIS_SET_I) [*2] |=> !SCAN_DIS_O)
        else $error("disable bit not cleared after two clocks");
    en_gate_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (!FUSE_EN_I || SCAN_DIS_O) |=> !SCAN_EN_O)
        else $error("port enabled without fuse or with disable bit");
    rst_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        $fell(rr_s_reg[1]) && !xr_low |=> CORE_RST_O [*2])
        else $error("core reset released before time-out");

    // -------------------------------------------------------------
    // Test-clock domain: controller and registers
    // -------------------------------------------------------------
    spp_tap_t    st_reg, st_next;
    logic [1:0]  en_s_reg, ack_s_reg;
    logic        ack_seen_reg;
    logic [3:0]  ir_sh_reg, ir_reg;
    logic [15:0] unl_reg;
    logic [14:0] cmd_sh_reg, cmd_sh_next, cmd_hold_reg, res_reg;
    logic [15:0] rd_reg;
    logic [7:0]  byte_tmp_reg;
    logic        byp_reg, hi_reg, first_reg, pend_reg;
    logic        ev_tgl_reg, ev_inc_reg, ev_hi_reg;
    spp_ev_t     ev_kind_reg;
    logic [14:0] snap_res_reg;
    logic [15:0] snap_rd_reg;
    logic        ack_tgl_reg;

    // Sixteen-state controller stepped by TMS.
    always_comb begin
        unique case (st_reg)
            ST_TLR:   st_next = TMS_I ? ST_TLR   : ST_RTI;
            ST_RTI:   st_next = TMS_I ? ST_SELDR : ST_RTI;
            ST_SELDR: st_next = TMS_I ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: st_next = TMS_I ? ST_EX1DR : ST_SHDR;
            ST_SHDR:  st_next = TMS_I ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: st_next = TMS_I ? ST_UPDR  : ST_PSDR;
            ST_PSDR:  st_next = TMS_I ? ST_EX2DR : ST_PSDR;
            ST_EX2DR: st_next = TMS_I ? ST_UPDR  : ST_SHDR;
            ST_UPDR:  st_next = TMS_I ? ST_SELDR : ST_RTI;
            ST_SELIR: st_next = TMS_I ? ST_TLR   : ST_CAPIR;
            ST_CAPIR: st_next = TMS_I ? ST_EX1IR : ST_SHIR;
            ST_SHIR:  st_next = TMS_I ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: st_next = TMS_I ? ST_UPIR  : ST_PSIR;
            ST_PSIR:  st_next = TMS_I ? ST_EX2IR : ST_PSIR;
            ST_EX2IR: st_next = TMS_I ? ST_UPIR  : ST_SHIR;
            ST_UPIR:  st_next = TMS_I ? ST_SELDR : ST_RTI;
        endcase
    end

    // State and instruction decode.
    wire tck_en  = en_s_reg[1];
    wire sh_dr   = st_reg == ST_SHDR;
    wire cap_dr  = st_reg == ST_CAPDR;
    wire upd_dr  = st_reg == ST_UPDR;
    wire is_cmd  = ir_reg == IR_CMD;
    wire is_load = ir_reg == IR_LOAD;
    wire is_read = ir_reg == IR_READ;
    wire is_page = is_load || is_read;
    wire ack_new = ack_s_reg[1] != ack_seen_reg;
    wire do_cmd  = st_reg == ST_RTI && pend_reg;
    wire do_load = upd_dr && is_load && prog_en_reg;
    wire do_rdc  = cap_dr && is_read && prog_en_reg;
    wire do_rdir = st_reg == ST_UPIR && ir_sh_reg == IR_READ && prog_en_reg;
    wire fire    = do_cmd || do_load || (do_rdc && hi_reg) || do_rdir;
    wire [7:0] rd_byte = hi_reg ? rd_reg[15:8] : rd_reg[7:0];
    wire dr_bit  = (ir_reg == IR_RESET)  ? rst_dr_reg :
                   (ir_reg == IR_UNLOCK) ? unl_reg[0] :
                   (is_cmd || is_page)   ? cmd_sh_reg[0] : byp_reg;
    wire tdo_bit = (st_reg == ST_SHIR) ? ir_sh_reg[0] : dr_bit;

    // Command register; page instructions reach only its low byte.
    assign cmd_sh_next =
        (cap_dr && is_cmd)  ? res_reg :
        (cap_dr && is_read) ? {cmd_sh_reg[14:8], rd_byte} :
        (sh_dr && is_cmd)   ? {TDI_I, cmd_sh_reg[14:1]} :
        (sh_dr && is_page)  ? {cmd_sh_reg[14:8], TDI_I,
                               cmd_sh_reg[7:1]} : cmd_sh_reg;

    // Controller, instruction and data shift registers.
    always_ff @(posedge TCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            en_s_reg   <= 2'h0;
            st_reg     <= ST_TLR;
            ir_sh_reg  <= IR_BYPASS;
            ir_reg     <= IR_BYPASS;
            rst_dr_reg <= 1'b0;
            unl_reg    <= UNLOCK_RST;
            byp_reg    <= 1'b0;
            cmd_sh_reg <= 15'h0000;
        end else begin
            en_s_reg   <= {en_s_reg[0], SCAN_EN_O};
            st_reg     <= tck_en ? st_next : ST_TLR;
            ir_sh_reg  <= (st_reg == ST_CAPIR) ? IR_CAPTURE :
                          (st_reg == ST_SHIR) ? {TDI_I, ir_sh_reg[3:1]} :
                          ir_sh_reg;
            // The reset register survives controller reset on purpose.
            ir_reg     <= (st_reg == ST_TLR) ? IR_BYPASS :
                          (st_reg == ST_UPIR) ? ir_sh_reg : ir_reg;
            rst_dr_reg <= (sh_dr && ir_reg == IR_RESET) ? TDI_I
                                                        : rst_dr_reg;
            unl_reg    <= (sh_dr && ir_reg == IR_UNLOCK) ?
                          {TDI_I, unl_reg[15:1]} : unl_reg;
            byp_reg    <= sh_dr ? TDI_I : 1'b0;
            cmd_sh_reg <= cmd_sh_next;
        end
    end

    // Unlock compare and the event sequencing toward the flash.
    always_ff @(posedge TCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            prog_en_reg  <= 1'b0;
            pend_reg     <= 1'b0;
            hi_reg       <= 1'b0;
            first_reg    <= 1'b1;
            cmd_hold_reg <= 15'h0000;
            byte_tmp_reg <= 8'h00;
            ev_tgl_reg   <= 1'b0;
            ev_kind_reg  <= EV_CMD;
            ev_inc_reg   <= 1'b0;
            ev_hi_reg    <= 1'b0;
        end else begin
            if (upd_dr && ir_reg == IR_UNLOCK)
                prog_en_reg <= unl_reg == UNLOCK_SIG;
            if (upd_dr && is_cmd && prog_en_reg) begin
                cmd_hold_reg <= cmd_sh_reg;
                pend_reg     <= 1'b1;
            end else if (do_cmd) begin
                pend_reg     <= 1'b0;
            end
            if (st_reg == ST_UPIR) begin
                hi_reg    <= 1'b0;
                first_reg <= 1'b1;
            end else if (do_load || do_rdc) begin
                hi_reg    <= !hi_reg;
                first_reg <= 1'b0;
            end
            if (do_load)
                byte_tmp_reg <= cmd_sh_reg[7:0];
            if (fire) begin
                ev_tgl_reg  <= !ev_tgl_reg;
                ev_kind_reg <= do_cmd ? EV_CMD : do_load ? EV_LOAD : EV_READ;
                ev_inc_reg  <= do_load ? (!hi_reg && !first_reg)
                                       : do_rdc;
                ev_hi_reg   <= hi_reg;
            end
        end
    end

    // Copy the system-side snapshot once its toggle has crossed.
    always_ff @(posedge TCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ack_s_reg    <= 2'h0;
            ack_seen_reg <= 1'b0;
            res_reg      <= 15'h0000;
            rd_reg       <= 16'h0000;
        end else begin
            ack_s_reg    <= {ack_s_reg[0], ack_tgl_reg};
            ack_seen_reg <= ack_s_reg[1];
            if (ack_new) begin
                res_reg <= snap_res_reg;
                rd_reg  <= snap_rd_reg;
            end
        end
    end

    // Output changes on the falling edge, clear of the sampling edge.
    always_ff @(negedge TCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            TDO_O    <= 1'b0;
            TDO_OE_O <= 1'b0;
        end else begin
            TDO_O    <= tdo_bit;
            TDO_OE_O <= sh_dr || st_reg == ST_SHIR;
        end
    end

    tap_tlr_a: assert property (@(posedge TCK_I) disable iff (!NRST_I)
        TMS_I [*5] |=> st_reg == ST_TLR)
        else $error("controller not in reset after five TMS ones");
    ir_upd_a: assert property (@(posedge TCK_I) disable iff (!NRST_I)
        st_reg == ST_UPIR |=> ir_reg == $past(ir_sh_reg))
        else $error("instruction not taken at update");
    unlock_cmp_a: assert property (@(posedge TCK_I) disable iff (!NRST_I)
        upd_dr && ir_reg == IR_UNLOCK
        |=> prog_en_reg == ($past(unl_reg) == UNLOCK_SIG))
        else $error("programming mode does not follow signature");
    lsb_first_a: assert property (@(posedge TCK_I) disable iff (!NRST_I)
        sh_dr && is_cmd |=> cmd_sh_reg[14] == $past(TDI_I)
                            && cmd_sh_reg[13:0] == $past(cmd_sh_reg[14:1]))
        else $error("command register shifted the wrong way");
    cmd_rti_a: assert property (@(posedge TCK_I) disable iff (!NRST_I)
        do_cmd |=> ev_kind_reg == EV_CMD && !pend_reg
                   && ev_tgl_reg != $past(ev_tgl_reg))
        else $error("command not executed in run-test/idle");
    load_alt_a: assert property (@(posedge TCK_I) disable iff (!NRST_I)
        do_load |=> hi_reg != $past(hi_reg) && ev_hi_reg == $past(hi_reg)
                    && ev_inc_reg == ($past(!hi_reg && !first_reg)))
        else $error("page load order or pre-increment wrong");
    read_inc_a: assert property (@(posedge TCK_I) disable iff (!NRST_I)
        do_rdc && hi_reg |=> ev_kind_reg == EV_READ && ev_inc_reg && !hi_reg)
        else $error("no post-increment after high byte read");

    // -------------------------------------------------------------
    // System domain: events from the test clock
    // -------------------------------------------------------------
    logic [2:0] ev_s_reg;
    logic       d1_reg, d2_reg;
    wire        ev_det = ev_s_reg[2] != ev_s_reg[1];

    // Event fields are held steady in the test domain until the next
    // toggle, which cannot arrive before this sequence has finished.
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ev_s_reg        <= 3'h0;
            d1_reg          <= 1'b0;
            d2_reg          <= 1'b0;
            ack_tgl_reg     <= 1'b0;
            snap_res_reg    <= 15'h0000;
            snap_rd_reg     <= 16'h0000;
            FLASH_CMD_O     <= 15'h0000;
            FLASH_CMD_STB_O <= 1'b0;
            PAGE_BYTE_O     <= 8'h00;
            PAGE_HIGH_O     <= 1'b0;
            PAGE_WR_STB_O   <= 1'b0;
            PC_INC_O        <= 1'b0;
        end else begin
            ev_s_reg        <= {ev_s_reg[1:0], ev_tgl_reg};
            d1_reg          <= ev_det;
            d2_reg          <= d1_reg;
            PC_INC_O        <= ev_det && ev_inc_reg;
            FLASH_CMD_STB_O <= d1_reg && ev_kind_reg == EV_CMD;
            PAGE_WR_STB_O   <= d1_reg && ev_kind_reg == EV_LOAD;
            if (ev_det) begin
                FLASH_CMD_O <= cmd_hold_reg;
                PAGE_BYTE_O <= byte_tmp_reg;
                PAGE_HIGH_O <= ev_hi_reg;
            end
            if (d2_reg) begin
                snap_res_reg <= FLASH_RESULT_I;
                snap_rd_reg  <= FLASH_RDATA_I;
                ack_tgl_reg  <= !ack_tgl_reg;
            end
        end
    end

    wr_strobe_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        ev_det && ev_kind_reg == EV_LOAD |=> ##1 PAGE_WR_STB_O
                                         && PAGE_BYTE_O == byte_tmp_reg)
        else $error("page byte not written two cycles after event");

endmodule

// ---- verif/spp_prog_model.sv ----
// Behavioural scan-port programmer that drives three test-port pins and samples TDO.
// Assumes the device changes TDO on the falling test-clock edge.
`timescale 1ns/1ns
module spp_prog_model (
    // Test port
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    // Clock rests low between frames; reset and clock pins stay untouched.
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // One 80 ns period keeps the test clock below the device clock rate.
    task automatic step(input logic m, input logic d, output logic o);
        tms_o = m;
        tdi_o = d;
        #40 tck_o = 1'b1;
        o = tdo_i;
        #40 tck_o = 1'b0;
    endtask
    // Walks n mode-select values, taken from m starting at bit 0.
    task automatic walk(input logic [7:0] m, input int n);
        logic o;
        for (int i = 0; i < n; i++) step(m[i], 1'b0, o);
    endtask
    // Five ones reach reset from any state, then the zero moves to idle.
    task automatic reset_tap();
        walk(8'h1f, 6);
    endtask
    task automatic idle(input int n);
        walk(8'h00, n);
    endtask
    // From idle: scan n bits, low bit first, update and return to idle.
    task automatic scan(input logic ir, input int n,
                        input logic [15:0] d, output logic [15:0] q);
        q = 16'h0000;
        #13;
        if (ir) walk(8'h03, 4); else walk(8'h01, 3);
        for (int i = 0; i < n; i++) step(i == n - 1, d[i], q[i]);
        walk(8'h01, 2);
    endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the scan-port programming block.
// Assumes the programmer model drives the test port on its own clock.
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
    import spp_pkg::*;
    logic ref_clk, nrst, ext_rst_n, fuse_en, dis_set, tck, tms, tdi;
    logic tdo, tdo_oe, cmd_stb, page_high, wr_stb, pc_inc;
    logic core_rst, prog_mode, scan_dis, scan_en;
    logic [CMD_W-1:0]  res, cmd, c, rr;
    logic [BYTE_W-1:0] pbyte, b;
    logic [15:0]       rdata, q, rev;
    logic [31:0]       seed = 32'd86957;
    logic [15:0]       exp_q[$];
    int                miscompares = 0, checks = 0, incs = 0;

    spp_prog_model pm (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    spp_scan_prog #(.RST_TMO(4)) DUT (
        .REF_CLK_I(ref_clk), .NRST_I(nrst), .EXT_RST_N_I(ext_rst_n),
        .FUSE_EN_I(fuse_en), .SCAN_DIS_SET_I(dis_set),
        .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
        .TDO_O(tdo), .TDO_OE_O(tdo_oe),
        .FLASH_RESULT_I(res), .FLASH_RDATA_I(rdata),
        .FLASH_CMD_O(cmd), .FLASH_CMD_STB_O(cmd_stb),
        .PAGE_BYTE_O(pbyte), .PAGE_HIGH_O(page_high),
        .PAGE_WR_STB_O(wr_stb), .PC_INC_O(pc_inc),
        .CORE_RST_O(core_rst), .PROG_MODE_O(prog_mode),
        .SCAN_DIS_O(scan_dis), .SCAN_EN_O(scan_en));

    // Xorshift keeps the random stream repeatable from run to run.
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // An unexpected strobe meets an empty queue and compares against ~v.
    task automatic pop(input logic [15:0] v);
        logic [15:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : ~v;
        `CHK(v, e)
    endtask

    // System clock, 50 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Watcher looks at settled strobes in the middle of each cycle.
    always @(negedge ref_clk) begin
        if (cmd_stb) pop({1'b0, cmd});
        if (wr_stb) pop({7'h00, page_high, pbyte});
        if (pc_inc) incs++;
    end
    // Watchdog: the sequence needs well under a tenth of this span.
    initial begin
        #800000;
        miscompares++;
        conclude();
    end
    // Main sequence.
    initial begin
        nrst = 1'b0; ext_rst_n = 1'b1; fuse_en = 1'b1; dis_set = 1'b0;
        res = xs() & 32'h7fff; rdata = 16'h0000;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk) nrst = 1'b1;
        `CHK(core_rst, 1'b1)
        repeat (4) @(negedge ref_clk);
        `CHK(scan_en, 1'b1)
        `CHK(prog_mode, 1'b0)
        pm.reset_tap();
        pm.scan(1'b1, 4, {12'h000, IR_RESET}, q);
        `CHK(q[3:0], IR_CAPTURE)
        pm.scan(1'b0, 1, 16'h0001, q);
        repeat (3) @(negedge ref_clk);
        `CHK(core_rst, 1'b1)
        pm.scan(1'b0, 1, 16'h0000, q);
        `CHK(core_rst, 1'b1)
        for (int i = 0; i < 40 && core_rst; i++) @(negedge ref_clk);
        `CHK(core_rst, 1'b0)
        $display("test reset register done");
        // Commands before unlock must not strobe; the watcher sees any.
        pm.scan(1'b1, 4, {12'h000, IR_CMD}, q);
        pm.scan(1'b0, 15, 16'h1234, q);
        pm.idle(8);
        rev = {<<{UNLOCK_SIG}};
        pm.scan(1'b1, 4, {12'h000, IR_UNLOCK}, q);
        pm.scan(1'b0, 16, rev, q);
        pm.idle(8);
        `CHK(prog_mode, 1'b0)
        pm.scan(1'b0, 16, UNLOCK_SIG, q);
        pm.idle(8);
        `CHK(prog_mode, 1'b1)
        `CHK(tdo_oe, 1'b0)
        $display("test unlock done");
        pm.scan(1'b1, 4, {12'h000, IR_CMD}, q);
        for (int i = 0; i < 2; i++) begin
            // The capture returns the result snapped for the last command.
            rr = res;
            @(negedge ref_clk) res = xs() & 32'h7fff;
            c = xs() & 32'h7fff;
            exp_q.push_back({1'b0, c});
            pm.scan(1'b0, 15, {1'b0, c}, q);
            pm.idle(8);
            if (i == 1) `CHK(q[14:0], rr)
        end
        `CHK(exp_q.size(), 0)
        $display("test commands done");
        pm.scan(1'b1, 4, {12'h000, IR_LOAD}, q);
        incs = 0;
        for (int i = 0; i < 3; i++) begin
            b = xs() & 32'hff;
            exp_q.push_back({7'h00, i[0], b});
            pm.scan(1'b0, 8, {8'h00, b}, q);
            pm.idle(8);
            `CHK(exp_q.size(), 0)
        end
        `CHK(incs, 1)
        $display("test page load done");
        @(negedge ref_clk) rdata = xs() & 32'hffff;
        pm.scan(1'b1, 4, {12'h000, IR_READ}, q);
        pm.idle(8);
        incs = 0;
        pm.scan(1'b0, 8, 16'h0000, q);
        `CHK(q[7:0], rdata[7:0])
        pm.idle(8);
        `CHK(incs, 0)
        pm.scan(1'b0, 8, 16'h0000, q);
        `CHK(q[7:0], rdata[15:8])
        pm.idle(8);
        `CHK(incs, 1)
        $display("test page read done");
        pm.scan(1'b1, 4, {12'h000, IR_UNLOCK}, q);
        pm.scan(1'b0, 16, 16'h0000, q);
        pm.idle(8);
        `CHK(prog_mode, 1'b0)
        @(negedge ref_clk) dis_set = 1'b1;
        @(negedge ref_clk) dis_set = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK(scan_dis, 1'b1)
        `CHK(scan_en, 1'b0)
        ext_rst_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        `CHK(scan_dis, 1'b0)
        `CHK(scan_en, 1'b1)
        `CHK(core_rst, 1'b1)
        ext_rst_n = 1'b1;
        // An unprogrammed enable fuse must take the port away.
        @(negedge ref_clk) fuse_en = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK(scan_en, 1'b0)
        fuse_en = 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK(scan_en, 1'b1)
        $display("test disable bit done");
        conclude();
    end
endmodule
